// File: core/field_memory_serial_write_port.sv
// Serial write port of a 256K x 8 field memory with its storage array.
// Assumes all write pins come from an outside controller with its own
// clock; they are synchronised into mclk, which must run well above the
// serial write clock rate. The array has a plain check read port.
`timescale 1ns/1ns

`include "fm_cfg.svh"

module field_memory_serial_write_port
    import fm_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  resetn,
    input  wire logic                  serial_write_clock,
    input  wire logic                  write_pointer_reset,
    input  wire logic                  write_gate,
    input  wire logic                  write_mask_enable,
    input  wire logic [`FM_DATA_W-1:0] write_data_in,
    input  wire logic [`FM_ADDR_W-1:0] check_read_addr,
    output logic      [`FM_DATA_W-1:0] check_read_data,
    output logic      [`FM_ADDR_W-1:0] write_addr,
    output logic                       capture_ready,
    output logic                       capture_overrun,
    output logic                       refresh_active
);
    localparam int PIN_W = 3 + `FM_DATA_W;
    localparam int WORD_W = `FM_ADDR_W + `FM_DATA_W;
    localparam logic [`FM_REF_CNT_W-1:0] REF_LAST =
        `FM_REF_CNT_W'(`FM_REFRESH_CYCLES - 1);
    localparam logic [`FM_REF_CNT_W-1:0] BUSY_LAST =
        `FM_REF_CNT_W'(`FM_REFRESH_BUSY_CYC - 1);

    // Storage array, 512 rows by 512 columns of bytes
    logic [`FM_DATA_W-1:0] array_mem [`FM_WORDS];

    // Pin synchroniser stages
    logic [PIN_W-1:0]       pin_raw;
    logic [PIN_W-1:0]       pin_meta_reg;
    logic [PIN_W-1:0]       pin_sync_reg;
    logic                   clk_meta_reg;
    logic                   clk_sync_reg;
    logic                   clk_prev_reg;
    write_pins_t            pins;
    logic                   wclk_rise;

    // Write side state
    logic [`FM_ADDR_W-1:0]  wptr_reg;
    logic [`FM_ADDR_W-1:0]  wptr_next;
    array_word_t            staged_reg;
    logic                   staged_valid_reg;
    logic                   staged_mask_reg;
    logic                   flush_now;
    logic                   push_valid;
    logic                   push_ready;
    logic                   overrun_reg;

    // Array side state
    array_word_t            drain_word;
    logic [WORD_W-1:0]      drain_bits;
    logic                   drain_valid;
    logic                   drain_ready;
    arb_state_t             arb_reg;
    logic [`FM_REF_CNT_W-1:0] ref_cnt_reg;
    logic [`FM_REF_CNT_W-1:0] busy_cnt_reg;
    logic                   ref_pending_reg;
    logic [`FM_ROW_W-1:0]   ref_row_reg;
    logic [`FM_DATA_W-1:0]  rd_data_reg;

    // Bundle the raw pins in a fixed order
    assign pin_raw = {write_pointer_reset, write_gate,
                      write_mask_enable, write_data_in};

    // Two-stage synchroniser for each pin bit
    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_pin_sync
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    pin_meta_reg[gi] <= 1'b0;
                    pin_sync_reg[gi] <= 1'b0;
                end else begin
                    pin_meta_reg[gi] <= pin_raw[gi];
                    pin_sync_reg[gi] <= pin_meta_reg[gi];
                end
            end
        end
    endgenerate

    // Write clock synchroniser plus edge history
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            clk_meta_reg <= 1'b0;
            clk_sync_reg <= 1'b0;
            clk_prev_reg <= 1'b0;
        end else begin
            clk_meta_reg <= serial_write_clock;
            clk_sync_reg <= clk_meta_reg;
            clk_prev_reg <= clk_sync_reg;
        end
    end

    // Pins and clock share the same delay, so each edge sees the
    // levels that stood across the rising write clock edge
    assign pins      = write_pins_t'(pin_sync_reg);      // [RULE18]
    // A stopped write clock gives no edge and leaves all write side state intact
    assign wclk_rise = clk_sync_reg && !clk_prev_reg;     // [RULE13] [RULE16]

    // Next pointer value for each edge kind
    always_comb begin
        wptr_next = wptr_reg;
        if (wclk_rise) begin
            if (pins.ptr_reset) begin
                wptr_next = `FM_ADDR_RESET;               // [RULE4]
            end else if (pins.gate) begin
                // Mask enable plays no part in advancing
                wptr_next = wptr_reg + 1'b1;              // [RULE7] [RULE11]
            end
        end
    end

    // Write address pointer; held while gate is low for any length
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wptr_reg <= `FM_ADDR_RESET;
        end else begin
            wptr_reg <= wptr_next;                        // [RULE8] [RULE9]
        end
    end

    // A word leaves the staging register on the next gated edge or on a
    // pointer reset, which flushes the last word of a sequence
    assign flush_now  = wclk_rise && (pins.ptr_reset || pins.gate);
    assign push_valid = flush_now && staged_valid_reg &&
                        staged_mask_reg;                  // [RULE3] [RULE10]

    // Staging register, the serial buffer ahead of the array.
    // Captures immediately, so the first word after reset waits on nothing
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            staged_reg       <= '0;
            staged_valid_reg <= 1'b0;
            staged_mask_reg  <= 1'b0;
        end else if (wclk_rise) begin
            if (pins.ptr_reset) begin
                // Gate and mask are ignored in the reset cycle
                staged_valid_reg <= 1'b0;                 // [RULE5] [RULE3]
            end else if (pins.gate) begin
                staged_reg.addr  <= wptr_reg;             // [RULE7] [RULE17]
                staged_reg.data  <= pins.data;            // [RULE7]
                staged_mask_reg  <= pins.mask_en;         // [RULE10]
                staged_valid_reg <= 1'b1;
            end
        end
    end

    // Lost word flag: set by a flush the buffer cannot take, cleared by
    // a pointer reset; a set in the same cycle wins
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            overrun_reg <= 1'b0;
        end else if (push_valid && !push_ready) begin
            overrun_reg <= 1'b1;
        end else if (wclk_rise && pins.ptr_reset) begin
            overrun_reg <= 1'b0;
        end
    end

    // Capture buffer between the write port and the array
    fm_word_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (`FM_FIFO_DEPTH)
    ) u_word_fifo (
        .mclk      (mclk),
        .resetn    (resetn),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (staged_reg),
        .out_valid (drain_valid),
        .out_ready (drain_ready),
        .out_data  (drain_bits)
    );

    assign drain_word = array_word_t'(drain_bits);

    // Array writes yield to a pending or running refresh
    assign drain_ready = (arb_reg == ARB_IDLE) &&
                         !ref_pending_reg;                // [RULE14]

    // Refresh interval timer; request set wins over its acceptance
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ref_cnt_reg     <= '0;
            ref_pending_reg <= 1'b0;
        end else begin
            if (ref_cnt_reg == REF_LAST) begin
                ref_cnt_reg     <= '0;
                ref_pending_reg <= 1'b1;                  // [RULE14]
            end else begin
                ref_cnt_reg <= ref_cnt_reg + 1'b1;
                if (arb_reg == ARB_IDLE) begin
                    ref_pending_reg <= 1'b0;
                end
            end
        end
    end

    // Arbiter between refresh and array writes
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            arb_reg      <= ARB_IDLE;
            busy_cnt_reg <= '0;
            ref_row_reg  <= `FM_ROW_RESET;
        end else begin
            case (arb_reg)
                ARB_IDLE: begin
                    if (ref_pending_reg) begin
                        arb_reg      <= ARB_REFRESH;      // [RULE14]
                        busy_cnt_reg <= '0;
                    end
                end
                ARB_REFRESH: begin
                    if (busy_cnt_reg == BUSY_LAST) begin
                        arb_reg     <= ARB_IDLE;
                        ref_row_reg <= ref_row_reg + 1'b1;
                    end else begin
                        busy_cnt_reg <= busy_cnt_reg + 1'b1;
                    end
                end
                default: begin
                    arb_reg <= ARB_IDLE;
                end
            endcase
        end
    end

    // Array write; masked words never arrive, so their cells keep
    // what they held
    always_ff @(posedge mclk) begin
        if (drain_valid && drain_ready) begin
            array_mem[drain_word.addr] <= drain_word.data; // [RULE12] [RULE15]
        end
    end

    // Check read port, one cycle of latency
    always_ff @(posedge mclk) begin
        rd_data_reg <= array_mem[check_read_addr];
    end

    assign check_read_data = rd_data_reg;
    assign write_addr      = wptr_reg;
    assign capture_ready   = push_ready;
    assign capture_overrun = overrun_reg;
    assign refresh_active  = (arb_reg == ARB_REFRESH);

endmodule // field_memory_serial_write_port

// File: core/fm_cfg.svh
// Constants of the field memory serial write port: sizes, timing, resets.
// Included by the package and the top design module; definitions only.
//
// Contract
// RULE1 - Controller writes by clocking with gate high
// RULE2 - Each write sequence needs 80 gated clocks
// RULE3 - Last word flushed into array by pointer reset
// RULE4 - Pointer reset clears write address at edge
// RULE5 - Gate and mask ignored in reset cycle
// RULE6 - Pointer reset low two clocks before again
// RULE7 - Gate high: edge captures data, advances pointer
// RULE8 - Gate low: no capture, pointer holds
// RULE9 - Gate may stay low or high indefinitely
// RULE10 - Array written only when mask enable high
// RULE11 - Pointer advances regardless of mask enable
// RULE12 - Masked locations keep previous contents
// RULE13 - Write clock may stop at any level
// RULE14 - Internal refresh, arbitrated against array writes
// RULE15 - Array is 512 rows by 512 columns bytes
// RULE16 - Write port clock independent of read side
// RULE17 - Serial buffer gives first access no latency
// RULE18 - Inputs sampled on rising write clock edge
// RULE19 - Power-up needs 80 dummy clocks then reset
`ifndef FM_CFG_SVH
`define FM_CFG_SVH

// Array geometry
`define FM_ROWS             512
`define FM_COLS             512
`define FM_ROW_W            9
`define FM_COL_W            9
`define FM_ADDR_W           18
`define FM_DATA_W           8
`define FM_WORDS            (`FM_ROWS * `FM_COLS)

// Pin synchroniser depth and capture buffer depth
`define FM_SYNC_STAGES      2
`define FM_FIFO_DEPTH       16

// Reset values
`define FM_ADDR_RESET       18'h00000
`define FM_DATA_RESET       8'h00
`define FM_ROW_RESET        9'h000

// Timing: clock period and refresh spacing in ns
`define FM_CLK_PERIOD_NS    8
`define FM_REFRESH_NS       7800
`define FM_REFRESH_BUSY_NS  32
// Longest spacing rounds down, busy time rounds up
`define FM_REFRESH_CYCLES   (`FM_REFRESH_NS / `FM_CLK_PERIOD_NS)
`define FM_REFRESH_BUSY_CYC \
    ((`FM_REFRESH_BUSY_NS + `FM_CLK_PERIOD_NS - 1) / `FM_CLK_PERIOD_NS)
`define FM_REF_CNT_W        10

`endif

// File: core/fm_pkg.sv
// Types shared by the field memory serial write port modules.
// Assumes fm_cfg.svh sits on the include path.
`include "fm_cfg.svh"

package fm_pkg;

    // One sampled set of write port pins
    typedef struct packed {
        logic                   ptr_reset;
        logic                   gate;
        logic                   mask_en;
        logic [`FM_DATA_W-1:0]  data;
    } write_pins_t;

    // One word bound for the storage array
    typedef struct packed {
        logic [`FM_ADDR_W-1:0]  addr;
        logic [`FM_DATA_W-1:0]  data;
    } array_word_t;

    // Array access arbitration
    typedef enum logic [0:0] {
        ARB_IDLE,
        ARB_REFRESH
    } arb_state_t;

endpackage

// File: core/fm_word_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock, mclk, and an asynchronous active-low reset.
`timescale 1ns/1ns

module fm_word_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_reg [DEPTH];
    logic [PW:0]      wr_ptr_reg;
    logic [PW:0]      rd_ptr_reg;
    logic             push;
    logic             pop;

    // Full when pointers differ only in the wrap bit
    assign in_ready  = !((wr_ptr_reg[PW] != rd_ptr_reg[PW]) &&
                         (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]));
    assign out_valid = (wr_ptr_reg != rd_ptr_reg);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = store_reg[rd_ptr_reg[PW-1:0]];

    // Storage write
    always_ff @(posedge mclk) begin
        if (push) begin
            store_reg[wr_ptr_reg[PW-1:0]] <= in_data;
        end
    end

    // Fill pointer
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_reg <= '0;
        end else if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
    end

    // Drain pointer
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rd_ptr_reg <= '0;
        end else if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end

endmodule // fm_word_fifo

// File: dv/fm_write_ctl_model.sv
// Model of the video controller that drives the serial write pins.
// Assumes mclk is the bench clock; each pin level lasts at least 4 mclk.
`timescale 1ns/1ns

module fm_write_ctl_model (
    input  wire logic mclk,
    output logic       serial_write_clock,
    output logic       write_pointer_reset,
    output logic       write_gate,
    output logic       write_mask_enable,
    output logic [7:0] write_data_in
);
    // Idle pin levels, write clock stopped low
    initial begin
        serial_write_clock  = 1'b0;
        write_pointer_reset = 1'b0;
        write_gate          = 1'b0;
        write_mask_enable   = 1'b0;
        write_data_in       = 8'h00;
    end

    // One write clock cycle; pins set while the clock is low
    task automatic wclk(input logic rst, g, m, input logic [7:0] d);
        @(posedge mclk);
        #1 write_pointer_reset = rst;
        write_gate = g;
        write_mask_enable = m;
        write_data_in = g ? d : ~d; // Unused data is scrambled
        repeat (4) @(posedge mclk);
        #1 serial_write_clock = 1'b1;
        repeat (4) @(posedge mclk);
        #1 serial_write_clock = 1'b0;
    endtask
endmodule // fm_write_ctl_model

// File: dv/fm_write_port_properties.sv
// Checker of write pointer, reset values and refresh slot timing.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
`include "fm_cfg.svh"

module fm_write_port_properties (
    input wire logic                  mclk,
    input wire logic                  resetn,
    input wire logic                  serial_write_clock,
    input wire logic                  write_pointer_reset,
    input wire logic                  write_gate,
    input wire logic [`FM_ADDR_W-1:0] write_addr,
    input wire logic                  capture_ready,
    input wire logic                  capture_overrun,
    input wire logic                  refresh_active
);
    logic                  clk_d_reg;
    logic [`FM_ADDR_W-1:0] addr_at_rise_reg;
    logic                  rise;

    // Pin rise as seen on mclk, and pointer at that moment
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            clk_d_reg <= 1'b0;
            addr_at_rise_reg <= '0;
        end else begin
            clk_d_reg <= serial_write_clock;
            if (rise)
                addr_at_rise_reg <= write_addr;
        end
    end
    assign rise = serial_write_clock & ~clk_d_reg;

    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    ptr_clear_a: assert property (
        rise && write_pointer_reset |-> ##[2:3] write_addr == '0)
        else $error("pointer reset did not clear write address");
    gated_advance_a: assert property (
        rise && write_gate && !write_pointer_reset
        |-> ##[2:3] write_addr == addr_at_rise_reg + 18'h00001)
        else $error("gated clock did not advance pointer");
    gate_low_hold_a: assert property (
        rise && !write_gate && !write_pointer_reset
        |-> $stable(write_addr)[*5])
        else $error("pointer moved with gate low");
    move_on_clock_a: assert property (
        $changed(write_addr) |-> $past(rise, 2) || $past(rise, 3))
        else $error("pointer moved without a write clock");
    seq_step_a: assert property (
        $changed(write_addr) |-> write_addr == '0
            || write_addr == $past(write_addr) + 18'h00001)
        else $error("pointer skipped an address");
    reset_state_a: assert property (
        $rose(resetn) |-> write_addr == '0 && capture_ready
            && !capture_overrun && !refresh_active)
        else $error("wrong state after reset");
    refresh_slot_a: assert property (
        $rose(refresh_active) |-> refresh_active[*4] ##1 !refresh_active)
        else $error("refresh slot length wrong");
    refresh_gap_a: assert property (
        $fell(refresh_active)
        |-> !refresh_active[*8] ##[1:1000] refresh_active)
        else $error("refresh spacing wrong");
endmodule // fm_write_port_properties

bind field_memory_serial_write_port fm_write_port_properties chk (
    .mclk, .resetn, .serial_write_clock, .write_pointer_reset,
    .write_gate, .write_addr, .capture_ready, .capture_overrun,
    .refresh_active);

// File: dv/testbench.sv
// Self-checking bench of the serial write port with a controller model.
// Assumes the design, package and controller model are compiled first.
`timescale 1ns/1ns
`include "fm_cfg.svh"

module testbench;
    logic        mclk;
    logic        resetn;
    logic        swclk;
    logic        wrst;
    logic        gate;
    logic        mask;
    logic [7:0]  din;
    logic [17:0] rd_addr;
    logic [7:0]  rd_data;
    logic [17:0] waddr;
    int          error_cnt;
    int          checks_done;

    fm_write_ctl_model ctl (.mclk(mclk), .serial_write_clock(swclk),
        .write_pointer_reset(wrst), .write_gate(gate),
        .write_mask_enable(mask), .write_data_in(din));

    field_memory_serial_write_port uut (.mclk(mclk), .resetn(resetn),
        .serial_write_clock(swclk), .write_pointer_reset(wrst),
        .write_gate(gate), .write_mask_enable(mask),
        .write_data_in(din), .check_read_addr(rd_addr),
        .check_read_data(rd_data), .write_addr(waddr),
        .capture_ready(), .capture_overrun(), .refresh_active());

    // Clock at 125 MHz
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Compare and count
    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Read one array word through the check port
    task automatic rd(input logic [17:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1 rd_addr = a;
        repeat (2) @(posedge mclk);
        #1 d = rd_data;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Dummy clocks fill 0..79, then a reset with gate and mask high
    task automatic t_init();
        for (int i = 0; i < 80; i++)
            ctl.wclk(1'b0, 1'b1, 1'b1, 8'h3C);
        chk(waddr, 18'h00050);
        ctl.wclk(1'b1, 1'b1, 1'b1, 8'hFF);
        chk(waddr, 18'h00000);
        $display("test init done");
    endtask

    // Masked rewrite with a gate-low pause, idle, then flush and read
    task automatic t_mask();
        logic [7:0] d;
        logic [7:0] exp;
        for (int i = 0; i < 80; i++) begin
            if (i == 40) begin
                repeat (3) ctl.wclk(1'b0, 1'b0, 1'b1, 8'h11);
                chk(waddr, 18'h00028);
            end
            ctl.wclk(1'b0, 1'b1, (i % 3) != 0, 8'(i) ^ 8'hA5);
            chk(waddr, 18'(i + 1));
        end
        repeat (400) @(posedge mclk);
        chk(waddr, 18'h00050);
        rd(18'h0004F, d);
        chk({10'h000, d}, 18'h0003C);
        ctl.wclk(1'b1, 1'b0, 1'b0, 8'h00);
        repeat (10) @(posedge mclk);
        chk(waddr, 18'h00000);
        for (int i = 0; i < 80; i++) begin
            exp = ((i % 3) != 0) ? (8'(i) ^ 8'hA5) : 8'h3C;
            rd(18'(i), d);
            chk({10'h000, d}, {10'h000, exp});
        end
        $display("test mask done");
    endtask

    // Watchdog
    initial begin
        #100000;
        error_cnt++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        error_cnt = 0;
        checks_done = 0;
        rd_addr = 18'h00000;
        resetn = 1'b0;
        repeat (3) @(posedge mclk);
        #1 resetn = 1'b1;
        t_init();
        t_mask();
        tally_and_finish();
    end
endmodule // testbench
